// ---- rtl/gauge_defs.vh ----
/*
 * Constants of the gauge mode sequencer and command port: standard command
 * codes, control subcommands, status bit positions, timing.
 * Assumes it is included by bare name from the rtl files.
 */
`ifndef GAUGE_DEFS_VH
`define GAUGE_DEFS_VH

// standard command codes (byte address of the low byte)
`define CMD_CONTROL 8'h00
`define CMD_THERMAL 8'h02
`define CMD_POTENTIAL 8'h04
`define CMD_STATUS_WORD 8'h06
`define CMD_NOMINAL_LEFT 8'h08
`define CMD_FULL_AVAIL 8'h0A
`define CMD_REMAINING 8'h0C
`define CMD_FULL_EST 8'h0E
`define CMD_MEAN_CURRENT 8'h10
`define CMD_DEBUG_ONE 8'h16
`define CMD_MEAN_POWER 8'h18
`define CMD_CHARGE_PCT 8'h1C
`define CMD_DIE_THERMAL 8'h1E
`define CMD_HEALTH 8'h20
`define CMD_DEBUG_TWO 8'h2C
`define CMD_DEBUG_THREE 8'h32
`define CMD_OP_SETTINGS 8'h3A
`define CMD_DESIGN_CAP 8'h3C

// control subcommands
`define SC_STATUS 16'h0000
`define SC_DEVICE_TYPE 16'h0001
`define SC_FW_REVISION 16'h0002
`define SC_LAST_ECHO 16'h0007
`define SC_CHEMISTRY 16'h0008
`define SC_INSERT 16'h000C
`define SC_REMOVE 16'h000D
`define SC_SET_HIB 16'h0011
`define SC_CLR_HIB 16'h0012
`define SC_RECONFIG 16'h0013
`define SC_SEAL 16'h0020
`define SC_FULL_RESET 16'h0041
`define SC_SOFT_RESET 16'h0042
`define SC_ECHO_LIMIT 16'h0015

// response selectors from the decoder
`define RSP_STATUS 3'h0
`define RSP_DEVICE_TYPE 3'h1
`define RSP_FW_REVISION 3'h2
`define RSP_LAST_ECHO 3'h3
`define RSP_CHEMISTRY 3'h4
`define RSP_KEEP 3'h5

// gauge status word bits
`define FL_OCV_TAKEN 7
`define FL_DEFAULTS 5
`define FL_CONFIG 4
`define FL_BATTERY 3
`define FL_OWN_MASK 16'h00B8

// control status bits
`define ST_SEALED 13
`define ST_QMAX_LEARNED 9
`define ST_RES_LEARNED 8
`define ST_HIB_REQ 6
`define ST_SLEEP 4
`define ST_CONST_POWER 3

// operation settings bits
`define OPC_PIN_ENABLE 13
`define OPC_SLEEP_EN 5
`define OPC_HOST_TEMP 0

// timing
`define CLK_HZ 40000000
`define TICK_PERIOD_MS 1000
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_PERIOD_MS)
`define RECONFIG_TIMEOUT_S 240
`define RECONFIG_TIMEOUT_TICKS (`RECONFIG_TIMEOUT_S * 1000 / `TICK_PERIOD_MS)

`endif

// ---- rtl/period_tick.v ----
/*
 * Free-running divider that emits a one-cycle tick every CYCLES clocks.
 * Assumes a single clock; counting pauses while ce_in is low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.vh"

module period_tick #(
    parameter CYCLES = `TICK_CYCLES
) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire ce_in,
    output reg tick_out
);
    reg [31:0] count_r;

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= 32'h0;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            if (count_r == CYCLES - 1) begin
                count_r <= 32'h0;
                tick_out <= 1'b1;
            end else begin
                count_r <= count_r + 32'h1;
                tick_out <= 1'b0;
            end
        end
    end
endmodule // period_tick

`default_nettype wire

// ---- rtl/subcmd_decode.v ----
/*
 * Combinational decode of a control subcommand into one action strobe or
 * a response selection, with sealed-mode gating.
 * Assumes the caller qualifies the outputs with its own write strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.vh"

module subcmd_decode (
    // subcommand and access state
    input wire [15:0] subcmd_in,
    input wire sealed_in,
    input wire pin_enable_in,
    // decoded actions
    output reg [2:0] rsp_sel_out,
    output reg insert_out,
    output reg remove_out,
    output reg set_hib_out,
    output reg clr_hib_out,
    output reg reconfig_out,
    output reg seal_out,
    output reg full_reset_out,
    output reg soft_reset_out
);
    always @* begin
        rsp_sel_out = `RSP_KEEP;
        insert_out = 1'b0;
        remove_out = 1'b0;
        set_hib_out = 1'b0;
        clr_hib_out = 1'b0;
        reconfig_out = 1'b0;
        seal_out = 1'b0;
        full_reset_out = 1'b0;
        soft_reset_out = 1'b0;
        case (subcmd_in)
            `SC_STATUS: rsp_sel_out = `RSP_STATUS;
            `SC_DEVICE_TYPE: rsp_sel_out = `RSP_DEVICE_TYPE;
            `SC_FW_REVISION: rsp_sel_out = `RSP_FW_REVISION;
            `SC_LAST_ECHO: rsp_sel_out = `RSP_LAST_ECHO;
            `SC_CHEMISTRY: rsp_sel_out = `RSP_CHEMISTRY;
            `SC_INSERT: insert_out = ~pin_enable_in;
            `SC_REMOVE: remove_out = ~pin_enable_in;
            `SC_SET_HIB: set_hib_out = 1'b1;
            `SC_CLR_HIB: clr_hib_out = 1'b1;
            `SC_RECONFIG: reconfig_out = ~sealed_in;
            `SC_SEAL: seal_out = ~sealed_in;
            `SC_FULL_RESET: full_reset_out = ~sealed_in;
            `SC_SOFT_RESET: soft_reset_out = ~sealed_in;
            default: rsp_sel_out = `RSP_KEEP;
        endcase
    end
endmodule // subcmd_decode

`default_nettype wire

// ---- rtl/gauge_mode_port.v ----
/*
 * Operating-mode sequencer and standard command port of a single-cell
 * battery gauge: power-on load, halted wait for a battery, initialisation,
 * normal, config update with time-out, sleep and hibernate, and the
 * control subcommand dispatcher with sealed-mode gating.
 * Assumes the serial link framing is done outside: each command arrives as
 * one code plus a word, synchronous to clk_sys_in; the measurement and
 * learning engine sits outside and answers on the calc and handshake ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.vh"

module gauge_mode_port #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter [15:0] DEVICE_TYPE = 16'h0A5A, // arbitrary value
    parameter [15:0] FW_REVISION = 16'h0100, // arbitrary value
    parameter [15:0] CHEMISTRY = 16'h0001 // arbitrary value
) (
    // clock, reset, enable
    input wire clk_sys_in,
    input wire rst_in,
    input wire ce_in,
    // command port
    input wire cmd_valid_in,
    input wire cmd_write_in,
    input wire [7:0] cmd_code_in,
    input wire [15:0] cmd_wdata_in,
    output reg cmd_ack_out,
    output reg [15:0] cmd_rdata_out,
    // bus wake events
    input wire addressed_in,
    input wire foreign_traffic_in,
    // configuration and thresholds
    input wire [15:0] operation_settings_in,
    input wire [15:0] sleep_current_in,
    input wire [15:0] hib_current_in,
    input wire [15:0] hib_voltage_in,
    // measurements
    input wire [15:0] cell_potential_in,
    input wire [15:0] mean_current_in,
    input wire [15:0] thermal_in,
    input wire [15:0] flags_ext_in,
    input wire bin_in,
    // algorithm data set
    output wire [7:0] calc_addr_out,
    input wire [15:0] calc_data_in,
    input wire qmax_learned_in,
    input wire res_learned_in,
    // engine handshakes
    output reg defaults_load_out,
    output reg ocv_start_out,
    input wire ocv_done_in,
    output reg adc_cal_start_out,
    input wire adc_cal_done_in,
    output reg measure_out,
    // status
    output wire gauging_out,
    output wire awake_out,
    output wire [3:0] mode_out
);
    localparam [3:0] ST_LOAD = 4'h0;
    localparam [3:0] ST_HALT = 4'h1;
    localparam [3:0] ST_INIT = 4'h2;
    localparam [3:0] ST_NORMAL = 4'h3;
    localparam [3:0] ST_RECONFIG = 4'h4;
    localparam [3:0] ST_SLEEP_CAL = 4'h5;
    localparam [3:0] ST_SLEEP = 4'h6;
    localparam [3:0] ST_HIB = 4'h7;
    localparam [3:0] ST_HIB_PEEK = 4'h8;

    reg [3:0] state_r, state_nxt;
    reg [7:0] timeout_r;
    reg defaults_flag_r, config_flag_r, ocv_taken_r;
    reg manual_bat_r, battery_detected_flag_r, bat_prev_r;
    reg qmax_r, res_r, hib_req_r, sealed_r;
    reg [15:0] ctl_resp_r, last_cmd_r, host_temp_r;
    reg [15:0] cell_potential_r, curr_r, temp_r;
    reg [15:0] rdata_nxt;

    wire tick;
    wire [2:0] rsp_sel;
    wire do_insert, do_remove, do_set_hib, do_clr_hib;
    wire do_reconfig, do_seal, do_full, do_soft;

    wire ctl_wr = ce_in & cmd_valid_in & cmd_write_in & (cmd_code_in == `CMD_CONTROL);
    wire pin_en = operation_settings_in[`OPC_PIN_ENABLE];
    wire bat_now = pin_en ? ~bin_in : manual_bat_r;
    wire inserted = battery_detected_flag_r & ~bat_prev_r;
    wire removed = ~battery_detected_flag_r & bat_prev_r;
    wire [15:0] abs_curr = curr_r[15] ? (16'h0 - curr_r) : curr_r;
    wire sleep_ok = operation_settings_in[`OPC_SLEEP_EN] &
                    ($signed(curr_r) < $signed(sleep_current_in));
    wire hib_ok = hib_req_r & ocv_taken_r & (abs_curr < hib_current_in);
    wire low_cell = cell_potential_r < hib_voltage_in;
    wire timed_out = tick & (timeout_r == `RECONFIG_TIMEOUT_TICKS - 1);

    wire [15:0] ctl_status = {2'b00, sealed_r, 3'b000, qmax_r, res_r,
                              1'b0, hib_req_r, 1'b0,
                              state_r == ST_SLEEP, 1'b1, 3'b000};
    wire [15:0] flags_word = (flags_ext_in & ~`FL_OWN_MASK) |
                             ({8'h00, ocv_taken_r, 1'b0, defaults_flag_r,
                               config_flag_r, battery_detected_flag_r, 3'b000});

    assign calc_addr_out = cmd_code_in;
    assign gauging_out = (state_r == ST_NORMAL) | (state_r == ST_SLEEP) |
                         (state_r == ST_SLEEP_CAL);
    // halted device counts as awake only while a command is served
    assign awake_out = ~((state_r == ST_HALT) | (state_r == ST_HIB)) |
                       cmd_valid_in;
    assign mode_out = state_r;

    period_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .tick_out(tick)
    );

    subcmd_decode u_decode (
        .subcmd_in(cmd_wdata_in),
        .sealed_in(sealed_r),
        .pin_enable_in(pin_en),
        .rsp_sel_out(rsp_sel),
        .insert_out(do_insert),
        .remove_out(do_remove),
        .set_hib_out(do_set_hib),
        .clr_hib_out(do_clr_hib),
        .reconfig_out(do_reconfig),
        .seal_out(do_seal),
        .full_reset_out(do_full),
        .soft_reset_out(do_soft)
    );

    // mode sequencing
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_LOAD: state_nxt = ST_HALT;
            ST_HALT: begin
                if (inserted)
                    state_nxt = ST_INIT;
            end
            ST_INIT: begin
                if (!battery_detected_flag_r)
                    state_nxt = ST_HALT;
                else if (ocv_done_in)
                    state_nxt = ST_NORMAL;
            end
            ST_NORMAL: begin
                if (tick && low_cell)
                    state_nxt = ST_HIB;
                else if (tick && sleep_ok)
                    state_nxt = ST_SLEEP_CAL;
            end
            ST_RECONFIG: begin
                if (timed_out)
                    state_nxt = ST_INIT;
            end
            ST_SLEEP_CAL: begin
                if (!sleep_ok)
                    state_nxt = ST_NORMAL;
                else if (adc_cal_done_in)
                    state_nxt = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (tick && (low_cell || hib_ok))
                    state_nxt = ST_HIB;
                else if (tick && !sleep_ok)
                    state_nxt = ST_NORMAL;
            end
            ST_HIB: begin
                if (addressed_in || (ctl_wr && do_clr_hib))
                    state_nxt = ST_INIT;
                else if (foreign_traffic_in)
                    state_nxt = ST_HIB_PEEK;
            end
            ST_HIB_PEEK: state_nxt = ST_HIB;
            default: state_nxt = ST_LOAD;
        endcase
        // removal drops any gauging mode back to the halted wait
        if (removed && state_r != ST_LOAD)
            state_nxt = ST_HALT;
        if (ctl_wr && do_reconfig)
            state_nxt = ST_RECONFIG;
        if (ctl_wr && do_soft)
            state_nxt = battery_detected_flag_r ? ST_INIT : ST_HALT;
        if (ctl_wr && do_full)
            state_nxt = ST_LOAD;
    end

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ST_LOAD;
            defaults_load_out <= 1'b0;
            ocv_start_out <= 1'b0;
            adc_cal_start_out <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            defaults_load_out <= (state_r == ST_LOAD);
            ocv_start_out <= (state_nxt == ST_INIT) && (state_r != ST_INIT);
            adc_cal_start_out <= (state_nxt == ST_SLEEP_CAL) &&
                                 (state_r != ST_SLEEP_CAL);
        end
    end

    // reconfig time-out in whole ticks
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            timeout_r <= 8'h00;
        end else if (ce_in) begin
            if (state_r != ST_RECONFIG || state_nxt != ST_RECONFIG)
                timeout_r <= 8'h00;
            else if (tick)
                timeout_r <= timeout_r + 8'h01;
        end
    end

    // periodic sampling; frozen while reconfig suspends gauging
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            measure_out <= 1'b0;
            cell_potential_r <= 16'h0000;
            curr_r <= 16'h0000;
            temp_r <= 16'h0000;
        end else if (ce_in) begin
            measure_out <= tick & gauging_out;
            if (tick && (gauging_out || state_r == ST_INIT)) begin
                cell_potential_r <= cell_potential_in;
                curr_r <= mean_current_in;
                temp_r <= thermal_in;
            end
        end
    end

    // status flags; an insertion clears the learned bits ahead of a learning set in the same cycle
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            defaults_flag_r <= 1'b1;
            config_flag_r <= 1'b0;
            ocv_taken_r <= 1'b0;
            manual_bat_r <= 1'b0;
            battery_detected_flag_r <= 1'b0;
            bat_prev_r <= 1'b0;
            qmax_r <= 1'b0;
            res_r <= 1'b0;
            hib_req_r <= 1'b0;
            sealed_r <= 1'b0;
        end else if (ce_in) begin
            battery_detected_flag_r <= bat_now;
            bat_prev_r <= battery_detected_flag_r;
            if (state_r == ST_LOAD) begin
                defaults_flag_r <= 1'b1;
                config_flag_r <= 1'b0;
                ocv_taken_r <= 1'b0;
                manual_bat_r <= 1'b0;
                qmax_r <= 1'b0;
                res_r <= 1'b0;
                hib_req_r <= 1'b0;
            end else begin
                if (ctl_wr && do_insert)
                    manual_bat_r <= 1'b1;
                else if (ctl_wr && do_remove)
                    manual_bat_r <= 1'b0;
                if (ctl_wr && do_soft) begin
                    defaults_flag_r <= 1'b0;
                    config_flag_r <= 1'b0;
                end else if (ctl_wr && do_reconfig) begin
                    config_flag_r <= 1'b1;
                end else if (state_r == ST_RECONFIG && state_nxt != ST_RECONFIG) begin
                    config_flag_r <= 1'b0;
                end
                if (state_r == ST_INIT && ocv_done_in)
                    ocv_taken_r <= 1'b1;
                if (inserted) begin
                    qmax_r <= 1'b0;
                    res_r <= 1'b0;
                end else begin
                    if (qmax_learned_in)
                        qmax_r <= 1'b1;
                    if (res_learned_in && qmax_r)
                        res_r <= 1'b1;
                end
                if (ctl_wr && do_set_hib)
                    hib_req_r <= 1'b1;
                else if ((ctl_wr && do_clr_hib) ||
                         (state_r == ST_HIB && state_nxt == ST_INIT))
                    hib_req_r <= 1'b0;
                if (ctl_wr && do_seal)
                    sealed_r <= 1'b1;
            end
        end
    end

    // control response word and subcommand echo
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_resp_r <= 16'h0000;
            last_cmd_r <= 16'h0000;
        end else if (ce_in && ctl_wr) begin
            if (cmd_wdata_in < `SC_ECHO_LIMIT)
                last_cmd_r <= cmd_wdata_in;
            case (rsp_sel)
                `RSP_STATUS: ctl_resp_r <= ctl_status;
                `RSP_DEVICE_TYPE: ctl_resp_r <= DEVICE_TYPE;
                `RSP_FW_REVISION: ctl_resp_r <= FW_REVISION;
                `RSP_LAST_ECHO: ctl_resp_r <= last_cmd_r;
                `RSP_CHEMISTRY: ctl_resp_r <= CHEMISTRY;
                default: ctl_resp_r <= ctl_resp_r;
            endcase
        end
    end

    // host-supplied temperature only sticks when the option allows it
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            host_temp_r <= 16'h0000;
        end else if (ce_in && cmd_valid_in && cmd_write_in &&
                     cmd_code_in == `CMD_THERMAL &&
                     operation_settings_in[`OPC_HOST_TEMP]) begin
            host_temp_r <= cmd_wdata_in;
        end
    end

    // read mux of the standard command map
    always @* begin
        case (cmd_code_in)
            `CMD_CONTROL: rdata_nxt = ctl_resp_r;
            `CMD_THERMAL: rdata_nxt = operation_settings_in[`OPC_HOST_TEMP] ?
                                      host_temp_r : temp_r;
            `CMD_POTENTIAL: rdata_nxt = cell_potential_r;
            `CMD_STATUS_WORD: rdata_nxt = flags_word;
            `CMD_MEAN_CURRENT: rdata_nxt = curr_r;
            `CMD_OP_SETTINGS: rdata_nxt = operation_settings_in;
            `CMD_NOMINAL_LEFT, `CMD_FULL_AVAIL, `CMD_REMAINING, `CMD_FULL_EST,
            `CMD_DEBUG_ONE, `CMD_MEAN_POWER, `CMD_CHARGE_PCT, `CMD_DIE_THERMAL,
            `CMD_HEALTH, `CMD_DEBUG_TWO, `CMD_DEBUG_THREE, `CMD_DESIGN_CAP:
                rdata_nxt = calc_data_in;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // one code plus one word per request, answered next cycle
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_ack_out <= 1'b0;
            cmd_rdata_out <= 16'h0000;
        end else if (ce_in) begin
            cmd_ack_out <= cmd_valid_in;
            if (cmd_valid_in && !cmd_write_in)
                cmd_rdata_out <= rdata_nxt;
        end
    end
endmodule // gauge_mode_port

`default_nettype wire

// ---- verification/gauge_mode_props.sv ----
/* gauge_mode_props: concurrent checks on the mode sequencer ports.
   assumes one clock domain and the async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module gauge_mode_props (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // command port and wake events
    input wire logic ce_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_ack_out,
    input wire logic addressed_in,
    input wire logic foreign_traffic_in,
    // mode and handshakes
    input wire logic [3:0] mode_out,
    input wire logic gauging_out,
    input wire logic measure_out,
    input wire logic defaults_load_out,
    input wire logic ocv_start_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    property p_ack;
        ce_in && cmd_valid_in |=> cmd_ack_out;
    endproperty
    a_ack: assert property (p_ack) else $error("command not acknowledged");
    property p_load;
        mode_out == 4'h0 && ce_in |=> defaults_load_out && mode_out == 4'h1;
    endproperty
    a_load: assert property (p_load) else $error("default load missing");
    property p_halt;
        mode_out == 4'h1 |-> !gauging_out ##1 !measure_out;
    endproperty
    a_halt: assert property (p_halt) else $error("gauging while halted");
    property p_reconf;
        mode_out == 4'h4 ##1 mode_out != 4'h4 |-> mode_out inside {4'h0, 4'h1, 4'h2};
    endproperty
    a_reconf: assert property (p_reconf) else $error("bad reconfig exit");
    property p_sleep_cal;
        mode_out != 4'h6 ##1 mode_out == 4'h6 |-> $past(mode_out) == 4'h5;
    endproperty
    a_sleep_cal: assert property (p_sleep_cal) else $error("sleep without offset cal");
    property p_ocv;
        $rose(ocv_start_out) |-> mode_out == 4'h2 && $past(mode_out) != 4'h2;
    endproperty
    a_ocv: assert property (p_ocv) else $error("ocv start off init entry");
    property p_hib_stay;
        mode_out == 4'h7 && !addressed_in && !cmd_valid_in && !foreign_traffic_in
            |=> mode_out == 4'h7;
    endproperty
    a_hib_stay: assert property (p_hib_stay) else $error("hibernate left idle");
    property p_peek;
        mode_out == 4'h7 && foreign_traffic_in && !addressed_in && !cmd_valid_in
            |-> ##[1:2] mode_out == 4'h7;
    endproperty
    a_peek: assert property (p_peek) else $error("foreign traffic woke device");
    property p_gauge;
        gauging_out |-> mode_out inside {4'h3, 4'h5, 4'h6};
    endproperty
    a_gauge: assert property (p_gauge) else $error("gauging in wrong mode");
    c_reconf: cover property (mode_out == 4'h4);
    c_sleep: cover property (mode_out == 4'h6);
    c_hib: cover property (mode_out == 4'h7);
endmodule // gauge_mode_props
bind gauge_mode_port gauge_mode_props gauge_mode_props_inst (.*);
`default_nettype wire

// ---- verification/engine_model.sv ----
/* engine_model: stand-in for the measurement engine handshakes.
   assumes one clock; lag_in sets the answer delay. */
`timescale 1ns/1ps
`default_nettype none
module engine_model (
    // clock and answer delay
    input wire logic clk_sys_in,
    input wire logic [3:0] lag_in,
    // handshakes
    input wire logic ocv_start_in,
    input wire logic cal_start_in,
    output logic ocv_done_out,
    output logic cal_done_out
);
    logic [4:0] ocv_cnt_r = 5'h00;
    logic [4:0] cal_cnt_r = 5'h00;
    // zero lag still answers after the start pulse, never with it
    always @(posedge clk_sys_in) begin
        ocv_done_out <= ocv_cnt_r == 5'h01;
        cal_done_out <= cal_cnt_r == 5'h01;
        ocv_cnt_r <= ocv_start_in ? {1'b0, lag_in} + 5'h01 : ocv_cnt_r - {4'h0, |ocv_cnt_r};
        cal_cnt_r <= cal_start_in ? {1'b0, lag_in} + 5'h01 : cal_cnt_r - {4'h0, |cal_cnt_r};
    end
endmodule // engine_model
`default_nettype wire

// ---- verification/testbench.sv ----
/* testbench: host-side command sequences against the mode sequencer.
   assumes a 40 MHz clock and a tick shortened to 4 cycles. */
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.vh"
module testbench;
    logic clk_sys_in, rst_in, ce_in, cmd_valid_in, cmd_write_in, cmd_ack_out, addressed_in;
    logic foreign_traffic_in, bin_in, qmax_learned_in, res_learned_in, defaults_load_out;
    logic ocv_start_out, ocv_done_in, adc_cal_start_out, adc_cal_done_in, measure_out;
    logic gauging_out, awake_out;
    logic [3:0] mode_out, lag;
    logic [7:0] cmd_code_in, calc_addr_out;
    logic [15:0] cmd_wdata_in, cmd_rdata_out, operation_settings_in, sleep_current_in, rd;
    logic [15:0] hib_current_in, hib_voltage_in, cell_potential_in, mean_current_in;
    logic [15:0] thermal_in, flags_ext_in, calc_data_in;
    int err_total = 0;
    int samples_checked = 0;
    assign calc_data_in = {calc_addr_out, 8'h5A};
    gauge_mode_port #(.TICK_CYCLES(4)) gauge_mode_port_inst (.*);
    engine_model engine_model_inst (.clk_sys_in(clk_sys_in), .lag_in(lag),
        .ocv_start_in(ocv_start_out), .cal_start_in(adc_cal_start_out),
        .ocv_done_out(ocv_done_in), .cal_done_out(adc_cal_done_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one request per call; code and word driven together in one cycle, as the port takes them
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
        int n;
        @(negedge clk_sys_in);
        cmd_valid_in = 1'b1;
        cmd_write_in = w;
        cmd_code_in = c;
        cmd_wdata_in = d;
        @(negedge clk_sys_in);
        cmd_valid_in = 1'b0;
        for (n = 0; cmd_ack_out !== 1'b1 && n < 4; n++) @(negedge clk_sys_in);
        chk({15'h0000, cmd_ack_out}, 16'h0001, "ack");
        rd = cmd_rdata_out;
    endtask
    task automatic ctl(input logic [15:0] sc);
        xfer(1'b1, `CMD_CONTROL, sc);
        xfer(1'b0, `CMD_CONTROL, 16'h0000);
    endtask
    task automatic wait_mode(input logic [3:0] m, input int lim);
        int n;
        for (n = 0; mode_out !== m && n < lim; n++) @(negedge clk_sys_in);
        chk({12'h000, mode_out}, {12'h000, m}, "mode");
        if (n >= lim) stop_test();
    endtask
    initial begin
        rst_in = 1'b1;
        ce_in = 1'b1;
        bin_in = 1'b1;
        lag = 4'h0;
        {cmd_valid_in, cmd_write_in, addressed_in, foreign_traffic_in} = 4'h0;
        {qmax_learned_in, res_learned_in, cmd_code_in, cmd_wdata_in, flags_ext_in} = '0;
        operation_settings_in = 16'h0000;
        {sleep_current_in, hib_current_in, hib_voltage_in} = {16'h000A, 16'h0014, 16'h0BB8};
        {cell_potential_in, mean_current_in, thermal_in} = {16'h0E74, 16'h0032, 16'h0BA6};
        repeat (6) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        wait_mode(4'h1, 4);
        repeat (40) @(negedge clk_sys_in);
        wait_mode(4'h1, 1);
        chk({15'h0000, awake_out}, 16'h0000, "awake");
        xfer(1'b0, `CMD_STATUS_WORD, 16'h0000);
        chk(rd, 16'h0020, "flags");
        xfer(1'b0, 8'h12, 16'h0000);
        chk(rd, 16'h0000, "unmapped");
        xfer(1'b0, `CMD_HEALTH, 16'h0000);
        chk(rd, 16'h205A, "calc");
        @(negedge clk_sys_in) qmax_learned_in = 1'b1;
        @(negedge clk_sys_in) qmax_learned_in = 1'b0;
        xfer(1'b1, `CMD_CONTROL, `SC_INSERT);
        wait_mode(4'h2, 4);
        wait_mode(4'h3, 40);
        ctl(`SC_STATUS);
        chk(rd & 16'h2350, 16'h0000, "learned");
        ctl(`SC_FW_REVISION);
        chk(rd, 16'h0100, "revision");
        xfer(1'b1, `CMD_CONTROL, `SC_RECONFIG);
        wait_mode(4'h4, 4);
        xfer(1'b0, `CMD_STATUS_WORD, 16'h0000);
        chk(rd & 16'h0030, 16'h0030, "cfg flags");
        xfer(1'b1, `CMD_CONTROL, `SC_SOFT_RESET);
        wait_mode(4'h2, 4);
        xfer(1'b0, `CMD_STATUS_WORD, 16'h0000);
        chk(rd & 16'h0030, 16'h0000, "soft flags");
        wait_mode(4'h3, 40);
        xfer(1'b1, `CMD_CONTROL, `SC_RECONFIG);
        repeat (900) @(negedge clk_sys_in);
        wait_mode(4'h4, 1);
        wait_mode(4'h2, 100);
        lag = 4'h9;
        mean_current_in = 16'h0005;
        repeat (40) @(negedge clk_sys_in);
        wait_mode(4'h3, 1);
        operation_settings_in = 16'h0020;
        wait_mode(4'h5, 20);
        wait_mode(4'h6, 40);
        mean_current_in = 16'h0032;
        wait_mode(4'h3, 20);
        xfer(1'b1, `CMD_CONTROL, `SC_SET_HIB);
        ctl(`SC_STATUS);
        chk(rd & 16'h0040, 16'h0040, "hib req");
        mean_current_in = 16'h0005;
        wait_mode(4'h7, 300);
        @(negedge clk_sys_in) foreign_traffic_in = 1'b1;
        @(negedge clk_sys_in) foreign_traffic_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        wait_mode(4'h7, 1);
        @(negedge clk_sys_in) addressed_in = 1'b1;
        @(negedge clk_sys_in) addressed_in = 1'b0;
        wait_mode(4'h2, 4);
        ctl(`SC_STATUS);
        chk(rd & 16'h0040, 16'h0000, "hib clr");
        cell_potential_in = 16'h09C4;
        wait_mode(4'h7, 300);
        cell_potential_in = 16'h0E74;
        xfer(1'b1, `CMD_CONTROL, `SC_CLR_HIB);
        wait_mode(4'h2, 4);
        mean_current_in = 16'h0032;
        xfer(1'b1, `CMD_CONTROL, `SC_FULL_RESET);
        xfer(1'b0, `CMD_STATUS_WORD, 16'h0000);
        chk(rd & 16'h0020, 16'h0020, "full reset");
        xfer(1'b1, `CMD_CONTROL, `SC_INSERT);
        wait_mode(4'h3, 80);
        xfer(1'b1, `CMD_CONTROL, `SC_SEAL);
        xfer(1'b1, `CMD_CONTROL, `SC_RECONFIG);
        wait_mode(4'h3, 1);
        ctl(`SC_STATUS);
        chk(rd & 16'h2000, 16'h2000, "sealed");
        ctl(`SC_FW_REVISION);
        chk(rd, 16'h0100, "sealed rev");
        xfer(1'b1, `CMD_CONTROL, `SC_REMOVE);
        wait_mode(4'h1, 40);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
